// [hw/scc_defs.vh]
// Constants for the sleep and clock control block
`ifndef SCC_DEFS_VH
`define SCC_DEFS_VH
// Register offsets
`define SCC_ADDR_CORE_CTRL 4'h0
`define SCC_ADDR_OSC_TRIM 4'h1
`define SCC_ADDR_CLK_CFG 4'h2
`define SCC_ADDR_ASYNC_CFG 4'h3
`define SCC_ADDR_STATUS 4'h4
// Core control register fields
`define SCC_SE_BIT 7
`define SCC_SM_HI 6
`define SCC_SM_LO 4
`define SCC_CORE_CTRL_RST 8'h00
// Sleep mode codes
`define SCC_SM_IDLE 3'h0
`define SCC_SM_NOISE 3'h1
`define SCC_SM_PDOWN 3'h2
`define SCC_SM_PSAVE 3'h3
`define SCC_SM_STBY 3'h6
// Clock selection
`define SCC_CLOCK_SOURCE_SELECT_EXT 4'h0
`define SCC_SUT_NONE 2'h0
`define SCC_SUT_SHORT 2'h1
`define SCC_SUT_LONG 2'h2
// Timing
`define SCC_CLK_MHZ 125
`define SCC_WAKE_CK 6
`define SCC_WAKE_STALL 4
`define SCC_SHORT_US 4100
`define SCC_LONG_US 65000
// Reset-time trim source: signature row address
`define SCC_SIG_TRIM_ADDR 8'h00
`endif

// [hw/scc_sync.v]
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/10ps
module scc_sync #(
  parameter W = 1
) (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_ce,
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end
    else if (i_ce)
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  assign o_sync = sync_q;
endmodule // scc_sync

// [hw/scc_delay.v]
// Start-up delay counter: loads a count and flags when it has run out
`timescale 1ns/10ps
module scc_delay #(
  parameter W = 24
) (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_ce,
  input wire i_load,
  input wire [W-1:0] i_count,
  output wire o_busy,
  output wire o_done
);
  reg [W-1:0] cnt_q;
  reg busy_q;
  reg done_q;
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_q <= {W{1'b0}};
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (i_ce)
    begin
      done_q <= 1'b0;
      if (i_load)
      begin
        cnt_q <= i_count;
        busy_q <= 1'b1;
      end
      else if (busy_q)
      begin
        if (cnt_q <= {{(W-1){1'b0}}, 1'b1})
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        else
          cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
  assign o_busy = busy_q;
  assign o_done = done_q;
endmodule // scc_delay

// [hw/scc_top.v]
// Sleep mode sequencing and clock gating control
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "scc_defs.vh"
module scc_top #(
  parameter SHORT_CYC = `SCC_SHORT_US * `SCC_CLK_MHZ,
  parameter LONG_CYC = `SCC_LONG_US * `SCC_CLK_MHZ,
  parameter [7:0] FACTORY_TRIM = 8'h80
) (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_ce,
  // Register port
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // Core
  input wire i_sleep_instr,
  input wire i_irq_global_en,
  // Fuse-like configuration
  input wire [3:0] i_clock_source_select,
  input wire [1:0] i_startup_time_select,
  input wire i_ext_crystal,
  input wire i_adc_enabled,
  // Wake sources (same clock domain, from peripherals)
  input wire i_periph_irq,
  input wire i_adc_done_irq,
  input wire i_twi_match_irq,
  input wire i_mem_ready_irq,
  input wire i_async_tmr_irq,
  input wire i_wdt_reset,
  input wire i_bod_reset,
  // Pins: external interrupts and external reset
  input wire i_ext_irq_zero,
  input wire i_ext_irq_one,
  input wire i_ext_irq_level_mode,
  input wire i_ext_resetn_pin,
  // Clock enables and control/status outputs
  output reg o_cpu_clk_en,
  output reg o_flash_clk_en,
  output reg o_io_clk_en,
  output reg o_adc_clk_en,
  output reg o_osc_en,
  output reg o_async_timer_clk_en,
  output reg o_ext_clk_mode,
  output reg o_adc_start,
  output reg o_irq_take,
  output reg o_core_reset,
  output reg o_sleeping,
  output reg [7:0] o_trim_value
);
  // Counts arrive as 32-bit integers; 24 bits hold the longest time-out at this clock
  localparam [31:0] SHORT_W = SHORT_CYC;
  localparam [31:0] LONG_W = LONG_CYC;
  localparam [31:0] WAKE6_W = `SCC_WAKE_CK;
  localparam [31:0] STALL_W = `SCC_WAKE_STALL;
  localparam [23:0] SHORT_C = SHORT_W[23:0];
  localparam [23:0] LONG_C = LONG_W[23:0];
  localparam [23:0] WAKE6_C = WAKE6_W[23:0];
  localparam [23:0] STALL_C = STALL_W[23:0];

  localparam [2:0] ST_RUN = 3'h0;
  localparam [2:0] ST_SLEEP = 3'h1;
  localparam [2:0] ST_START = 3'h2;
  localparam [2:0] ST_STALL = 3'h3;
  localparam [2:0] ST_RSTWAIT = 3'h4;

  //------------------------------------------------------------
  // Helpers
  //------------------------------------------------------------
  // Reset time-out for a start-up code; code 11 is reserved and treated as longest
  function [23:0] reset_delay;
    input [1:0] startup_time_select;
    begin
      case (startup_time_select)
        `SCC_SUT_NONE: reset_delay = 24'h000001;
        `SCC_SUT_SHORT: reset_delay = SHORT_C;
        `SCC_SUT_LONG: reset_delay = LONG_C;
        default: reset_delay = LONG_C;
      endcase
    end
  endfunction

  function mode_valid;
    input [2:0] m;
    begin
      mode_valid = (m == `SCC_SM_IDLE) || (m == `SCC_SM_NOISE) || (m == `SCC_SM_PDOWN) ||
                   (m == `SCC_SM_PSAVE) || (m == `SCC_SM_STBY);
    end
  endfunction

  //------------------------------------------------------------
  // Pin synchronisers
  //------------------------------------------------------------
  wire [2:0] pin_s;
  scc_sync #(.W(3)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_async({~i_ext_resetn_pin, i_ext_irq_one, i_ext_irq_zero}),
    .o_sync(pin_s)
  );
  wire ext_irq_any = pin_s[0] | pin_s[1];
  wire ext_level = ext_irq_any & i_ext_irq_level_mode;
  wire ext_rst = pin_s[2];

  //------------------------------------------------------------
  // Registers
  //------------------------------------------------------------
  reg [7:0] core_ctrl_q;
  reg [7:0] trim_q;
  reg [1:0] async_cfg_q;
  reg trim_loaded_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [2:0] mode_q;
  reg [2:0] mode_d;
  reg irq_pend_q;
  reg irq_pend_d;
  reg dly_load;
  reg [23:0] dly_count;
  wire dly_busy;
  wire dly_done;

  wire sleep_en = core_ctrl_q[`SCC_SE_BIT];
  wire [2:0] mode_sel = core_ctrl_q[`SCC_SM_HI:`SCC_SM_LO];
  wire async_clk_sel = async_cfg_q[0];
  wire async_tmr_ie = async_cfg_q[1];
  wire any_reset = ext_rst | i_wdt_reset | i_bod_reset;

  // Register writes; trim is loaded once after reset release
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      core_ctrl_q <= `SCC_CORE_CTRL_RST;
      trim_q <= 8'h00;
      async_cfg_q <= 2'h0;
      trim_loaded_q <= 1'b0;
    end
    else if (i_ce)
    begin
      // A trim write in the first cycle after reset loses to the factory load
      if (!trim_loaded_q)
      begin
        trim_q <= FACTORY_TRIM;
        trim_loaded_q <= 1'b1;
      end
      else if (i_wr && i_addr == `SCC_ADDR_OSC_TRIM)
        trim_q <= i_wdata;
      if (i_wr && i_addr == `SCC_ADDR_CORE_CTRL)
        core_ctrl_q <= i_wdata;
      if (i_wr && i_addr == `SCC_ADDR_ASYNC_CFG)
        async_cfg_q <= i_wdata[1:0];
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_rdata <= 8'h00;
    else if (i_ce)
    begin
      o_rdata <= 8'h00;
      if (i_rd)
      begin
        case (i_addr)
          `SCC_ADDR_CORE_CTRL: o_rdata <= core_ctrl_q;
          `SCC_ADDR_OSC_TRIM: o_rdata <= trim_q;
          `SCC_ADDR_CLK_CFG: o_rdata <= {2'h0, i_startup_time_select, i_clock_source_select};
          `SCC_ADDR_ASYNC_CFG: o_rdata <= {6'h00, async_cfg_q};
          `SCC_ADDR_STATUS: o_rdata <= {3'h0, mode_q, irq_pend_q, state_q != ST_RUN};
          default: o_rdata <= 8'h00;
        endcase
      end
    end
  end

  //------------------------------------------------------------
  // Wake qualification per mode
  //------------------------------------------------------------
  reg wake_irq;
  always @*
  begin
    case (mode_q)
      `SCC_SM_IDLE: wake_irq = ext_irq_any | i_periph_irq | i_adc_done_irq |
                               i_twi_match_irq | i_mem_ready_irq | i_async_tmr_irq;
      `SCC_SM_NOISE: wake_irq = i_adc_done_irq | i_twi_match_irq | i_async_tmr_irq |
                                i_mem_ready_irq | ext_level;
      `SCC_SM_PSAVE: wake_irq = i_twi_match_irq | ext_level |
                                (async_clk_sel & async_tmr_ie & i_irq_global_en &
                                 i_async_tmr_irq);
      default: wake_irq = i_twi_match_irq | ext_level;
    endcase
  end

  //------------------------------------------------------------
  // Sleep sequencer
  //------------------------------------------------------------
  always @*
  begin
    state_d = state_q;
    mode_d = mode_q;
    irq_pend_d = irq_pend_q;
    dly_load = 1'b0;
    dly_count = WAKE6_C;
    case (state_q)
      ST_RUN:
      begin
        irq_pend_d = 1'b0;
        if (i_sleep_instr && sleep_en && mode_valid(mode_sel) &&
            !(mode_sel == `SCC_SM_STBY && !i_ext_crystal))
        begin
          state_d = ST_SLEEP;
          mode_d = mode_sel;
        end
      end
      ST_SLEEP:
      begin
        if (wake_irq)
        begin
          irq_pend_d = 1'b1;
          dly_load = 1'b1;
          state_d = ST_START;
          if (mode_q == `SCC_SM_PDOWN || mode_q == `SCC_SM_PSAVE)
            dly_count = reset_delay(i_startup_time_select);
          else
            dly_count = WAKE6_C;
        end
      end
      ST_START:
        if (dly_done)
        begin
          dly_load = 1'b1;
          dly_count = STALL_C;
          state_d = ST_STALL;
        end
      ST_STALL:
        if (dly_done)
          state_d = ST_RUN;
      ST_RSTWAIT:
        if (dly_done)
          state_d = ST_RUN;
      default: state_d = ST_RUN;
    endcase
    if (any_reset)
    begin
      state_d = ST_RSTWAIT;
      irq_pend_d = 1'b0;
      dly_load = 1'b1;
      dly_count = reset_delay(i_startup_time_select);
    end
  end

  //------------------------------------------------------------
  // Start-up delay counter
  //------------------------------------------------------------
  scc_delay #(.W(24)) u_delay (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_load(dly_load),
    .i_count(dly_count),
    .o_busy(dly_busy),
    .o_done(dly_done)
  );

  //------------------------------------------------------------
  // Clock enables and output registers
  //------------------------------------------------------------
  wire run_next = (state_d == ST_RUN);
  wire asleep_next = (state_d == ST_SLEEP) || (state_d == ST_START);
  // Oscillator restarts when the start-up delay begins, so it can settle during the count
  wire deep_next = (state_d == ST_SLEEP) && (mode_d == `SCC_SM_PDOWN ||
                                            mode_d == `SCC_SM_PSAVE || mode_d == `SCC_SM_STBY);

  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q <= ST_RUN;
      mode_q <= `SCC_SM_IDLE;
      irq_pend_q <= 1'b0;
      o_cpu_clk_en <= 1'b0;
      o_flash_clk_en <= 1'b0;
      o_io_clk_en <= 1'b1;
      o_adc_clk_en <= 1'b1;
      o_osc_en <= 1'b1;
      o_async_timer_clk_en <= 1'b1;
      o_ext_clk_mode <= 1'b0;
      o_adc_start <= 1'b0;
      o_irq_take <= 1'b0;
      o_core_reset <= 1'b1;
      o_sleeping <= 1'b0;
      o_trim_value <= 8'h00;
    end
    else if (i_ce)
    begin
      state_q <= state_d;
      mode_q <= mode_d;
      irq_pend_q <= irq_pend_d;
      // Processor and program clocks only run once all delays are over
      o_cpu_clk_en <= run_next && !dly_busy;
      o_flash_clk_en <= run_next && !dly_busy;
      o_io_clk_en <= !(asleep_next && mode_d != `SCC_SM_IDLE);
      o_adc_clk_en <= !deep_next;
      o_osc_en <= !(deep_next && mode_d != `SCC_SM_STBY);
      o_async_timer_clk_en <= !deep_next || (mode_d == `SCC_SM_PSAVE && async_clk_sel);
      o_ext_clk_mode <= (i_clock_source_select == `SCC_CLOCK_SOURCE_SELECT_EXT);
      o_adc_start <= (state_q == ST_RUN) && (state_d == ST_SLEEP) && i_adc_enabled &&
                     (mode_d == `SCC_SM_IDLE || mode_d == `SCC_SM_NOISE);
      o_irq_take <= (state_q == ST_STALL) && (state_d == ST_RUN) && irq_pend_q;
      o_core_reset <= (state_d == ST_RSTWAIT);
      o_sleeping <= (state_d == ST_SLEEP);
      o_trim_value <= trim_q;
    end
  end
endmodule // scc_top

// [sim/scc_top_sva.sv]
// Port checker of the sleep and clock control block
`timescale 1ns/10ps
module scc_top_sva (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_rd,
  input wire i_wdt_reset,
  input wire i_adc_enabled,
  input wire [3:0] i_clock_source_select,
  input wire i_sleep_instr,
  input wire [7:0] o_rdata,
  input wire o_cpu_clk_en,
  input wire o_flash_clk_en,
  input wire o_io_clk_en,
  input wire o_adc_clk_en,
  input wire o_osc_en,
  input wire o_ext_clk_mode,
  input wire o_adc_start,
  input wire o_irq_take,
  input wire o_core_reset,
  input wire o_sleeping
);
  //----------------------------------------
  // Properties
  //----------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);
  property p_entry;
    $rose(o_sleeping) |-> $past(i_sleep_instr);
  endproperty
  a_entry: assert property (p_entry) else $error("sleep without instruction");
  property p_gated;
    o_sleeping |-> !o_cpu_clk_en && !o_flash_clk_en;
  endproperty
  a_gated: assert property (p_gated) else $error("core clock runs in sleep");
  property p_take;
    o_irq_take |-> o_cpu_clk_en && !$past(o_cpu_clk_en);
  endproperty
  a_take: assert property (p_take) else $error("irq taken off resume edge");
  // Only the short wakes keep the oscillator; the reset time-out may be 1 cycle
  property p_wake_hold;
    $fell(o_sleeping) && $past(o_osc_en) && !o_core_reset |-> !o_cpu_clk_en [*8];
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("core resumed early");
  property p_pdown;
    o_sleeping && !o_osc_en |-> !o_io_clk_en && !o_adc_clk_en;
  endproperty
  a_pdown: assert property (p_pdown) else $error("clock runs in power-down");
  property p_ext;
    $past(i_resetn) |-> o_ext_clk_mode == ($past(i_clock_source_select) == 4'h0);
  endproperty
  a_ext: assert property (p_ext) else $error("external clock mode wrong");
  property p_rdata;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
  property p_rst;
    i_wdt_reset |=> o_core_reset;
  endproperty
  a_rst: assert property (p_rst) else $error("watchdog reset lost");
  property p_adc;
    o_adc_start |-> $rose(o_sleeping) && $past(i_adc_enabled);
  endproperty
  a_adc: assert property (p_adc) else $error("conversion start misplaced");
  c_sleep: cover property ($rose(o_sleeping));
  c_take: cover property (o_irq_take);
  c_adc: cover property (o_adc_start);
endmodule // scc_top_sva

bind scc_top scc_top_sva u_scc_top_sva (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
  .i_rd(i_rd), .i_wdt_reset(i_wdt_reset), .i_adc_enabled(i_adc_enabled),
  .i_clock_source_select(i_clock_source_select), .i_sleep_instr(i_sleep_instr),
  .o_rdata(o_rdata), .o_cpu_clk_en(o_cpu_clk_en), .o_flash_clk_en(o_flash_clk_en),
  .o_io_clk_en(o_io_clk_en), .o_adc_clk_en(o_adc_clk_en), .o_osc_en(o_osc_en),
  .o_ext_clk_mode(o_ext_clk_mode), .o_adc_start(o_adc_start), .o_irq_take(o_irq_take),
  .o_core_reset(o_core_reset), .o_sleeping(o_sleeping));

// [sim/scc_core_model.sv]
// Behavioural processor core issuing sleep instructions
`timescale 1ns/10ps
module scc_core_model (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_go,
  input wire i_irq_take,
  output reg o_sleep_instr,
  output wire o_irq_global_en,
  output reg [7:0] o_served
);
  assign o_irq_global_en = 1'b1;
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_sleep_instr <= 1'b0;
      o_served <= 8'h00;
    end
    else
    begin
      // One-cycle instruction per i_go pulse; the model issues it whenever i_go is high, halted or not
      o_sleep_instr <= i_go;
      if (i_irq_take)
        o_served <= o_served + 8'h01;
    end
  end
endmodule // scc_core_model

// [sim/sleep_and_clock_control_tb.sv]
// Self-checking bench of the sleep and clock control block
`timescale 1ns/10ps
`include "scc_defs.vh"
module sleep_and_clock_control_tb;
  typedef struct packed {
    logic se;
    logic [2:0] m;
    logic [4:0] bad;
    logic [4:0] good;
    logic sl;
    logic io;
    logic osc;
    logic [7:0] dly;
  } scc_row_t;
  // Wake bits: periph, conversion, address match, memory, async timer
  scc_row_t rows [8] = '{
    '{1'b0, 3'h0, 5'h00, 5'h10, 1'b0, 1'b1, 1'b1, 8'h06},
    '{1'b1, 3'h0, 5'h00, 5'h10, 1'b1, 1'b1, 1'b1, 8'h06},
    '{1'b1, 3'h1, 5'h10, 5'h08, 1'b1, 1'b0, 1'b1, 8'h06},
    '{1'b1, 3'h2, 5'h08, 5'h04, 1'b1, 1'b0, 1'b0, 8'h14},
    '{1'b1, 3'h3, 5'h08, 5'h01, 1'b1, 1'b0, 1'b0, 8'h14},
    '{1'b1, 3'h6, 5'h08, 5'h04, 1'b1, 1'b0, 1'b1, 8'h06},
    '{1'b1, 3'h4, 5'h00, 5'h00, 1'b0, 1'b0, 1'b0, 8'h00},
    '{1'b1, 3'h5, 5'h00, 5'h00, 1'b0, 1'b0, 1'b0, 8'h00}};
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic go = 1'b0;
  logic i_wdt_reset = 1'b0;
  logic i_bod_reset = 1'b0;
  logic i_ext_irq_zero = 1'b0;
  logic i_ext_resetn_pin = 1'b1;
  logic i_ce = 1'b1;
  logic i_ext_crystal = 1'b1;
  logic [3:0] i_clock_source_select = 4'h0;
  logic i_adc_enabled = 1'b1;
  logic [1:0] i_startup_time_select = 2'h1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic [4:0] wk = 5'h00;
  wire [7:0] o_rdata, o_trim_value, served;
  wire i_sleep_instr, i_irq_global_en, o_cpu_clk_en, o_flash_clk_en, o_io_clk_en, o_adc_clk_en;
  wire o_osc_en, o_async_timer_clk_en, o_ext_clk_mode, o_adc_start, o_irq_take, o_core_reset;
  wire o_sleeping;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  int adc_n = 0;
  always #4 i_sys_clk = ~i_sys_clk;
  scc_top #(.SHORT_CYC(20), .LONG_CYC(40)) u_scc_top (.i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep_instr(i_sleep_instr),
    .i_irq_global_en(i_irq_global_en), .i_clock_source_select(i_clock_source_select),
    .i_startup_time_select(i_startup_time_select), .i_ext_crystal(i_ext_crystal),
    .i_adc_enabled(i_adc_enabled), .i_periph_irq(wk[4]), .i_adc_done_irq(wk[3]),
    .i_twi_match_irq(wk[2]), .i_mem_ready_irq(wk[1]), .i_async_tmr_irq(wk[0]),
    .i_wdt_reset(i_wdt_reset), .i_bod_reset(i_bod_reset), .i_ext_irq_zero(i_ext_irq_zero),
    .i_ext_irq_one(1'b0), .i_ext_irq_level_mode(1'b1), .i_ext_resetn_pin(i_ext_resetn_pin),
    .o_cpu_clk_en(o_cpu_clk_en), .o_flash_clk_en(o_flash_clk_en), .o_io_clk_en(o_io_clk_en),
    .o_adc_clk_en(o_adc_clk_en), .o_osc_en(o_osc_en),
    .o_async_timer_clk_en(o_async_timer_clk_en), .o_ext_clk_mode(o_ext_clk_mode),
    .o_adc_start(o_adc_start), .o_irq_take(o_irq_take), .o_core_reset(o_core_reset),
    .o_sleeping(o_sleeping), .o_trim_value(o_trim_value));
  scc_core_model u_scc_core_model (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_go(go),
    .i_irq_take(o_irq_take), .o_sleep_instr(i_sleep_instr),
    .o_irq_global_en(i_irq_global_en), .o_served(served));
  //----------------------------------------
  // Shared tasks
  //----------------------------------------
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic nap;
    @(posedge i_sys_clk) go <= 1'b1;
    @(posedge i_sys_clk) go <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wait_for(input logic want, output int n);
    n = 0;
    while (((want ? o_irq_take : o_core_reset) !== want) && n < 200)
    begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
  endtask
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (o_adc_start === 1'b1)
      adc_n++;
    // Whole run needs about 330 cycles
    if (cycles == 6000)
    begin
      miscompares++;
      close_out;
    end
  end
  //----------------------------------------
  // Main sequence
  //----------------------------------------
  initial
  begin
    scc_row_t r;
    logic [7:0] d;
    logic [7:0] s0;
    int a0;
    int n;
    repeat (10) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    wr(`SCC_ADDR_ASYNC_CFG, 8'h03);
    foreach (rows[i])
    begin
      r = rows[i];
      a0 = adc_n;
      s0 = served;
      wr(`SCC_ADDR_CORE_CTRL, {r.se, r.m, 4'h0});
      @(posedge i_sys_clk) go <= 1'b1;
      @(posedge i_sys_clk) go <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      #1;
      chk(o_sleeping, r.sl);
      if (r.sl)
      begin
        chk(o_io_clk_en, r.io);
        chk(o_osc_en, r.osc);
        if (r.m == `SCC_SM_PSAVE)
          chk(o_async_timer_clk_en, 1'b1);
        chk(8'(adc_n - a0), 8'(r.m < 3'h2));
        @(posedge i_sys_clk) wk <= r.bad;
        repeat (4) @(posedge i_sys_clk);
        #1;
        chk(o_sleeping, 1'b1);
        @(posedge i_sys_clk) wk <= r.good;
        wait_for(1'b1, n);
        @(posedge i_sys_clk) wk <= 5'h00;
        #1;
        chk(8'(n >= r.dly + 4 && n <= r.dly + 10), 8'h01);
        chk(served - s0, 8'h01);
      end
      $display("Test row %0d done", i);
    end
    wr(`SCC_ADDR_CORE_CTRL, 8'hA0);
    @(posedge i_sys_clk) go <= 1'b1;
    @(posedge i_sys_clk) go <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_wdt_reset <= 1'b1;
    @(posedge i_sys_clk) i_wdt_reset <= 1'b0;
    #1;
    chk(o_core_reset, 1'b1);
    wait_for(1'b0, n);
    chk(o_sleeping, 1'b0);
    chk(8'(n < 200), 8'h01);
    $display("Test reset in sleep done");
    @(posedge i_sys_clk) i_ext_resetn_pin <= 1'b0;
    @(posedge i_sys_clk) i_ext_resetn_pin <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    #1;
    chk(o_core_reset, 1'b1);
    wait_for(1'b0, n);
    chk(8'(n < 200), 8'h01);
    @(posedge i_sys_clk) i_ext_crystal <= 1'b0;
    wr(`SCC_ADDR_CORE_CTRL, 8'hE0);
    nap;
    chk(o_sleeping, 1'b0);
    @(posedge i_sys_clk) i_ext_crystal <= 1'b1;
    wr(`SCC_ADDR_CORE_CTRL, 8'hA0);
    nap;
    chk(o_sleeping, 1'b1);
    @(posedge i_sys_clk) i_ext_irq_zero <= 1'b1;
    wait_for(1'b1, n);
    @(posedge i_sys_clk) i_ext_irq_zero <= 1'b0;
    chk(8'(n >= 24 && n <= 34), 8'h01);
    $display("Test pin wake and pin reset done");
    wr(`SCC_ADDR_OSC_TRIM, 8'h3C);
    rd(`SCC_ADDR_OSC_TRIM, d);
    chk(d, 8'h3C);
    chk(o_trim_value, 8'h3C);
    @(posedge i_sys_clk) i_ce <= 1'b0;
    wr(`SCC_ADDR_OSC_TRIM, 8'h55);
    i_ce <= 1'b1;
    rd(`SCC_ADDR_OSC_TRIM, d);
    chk(d, 8'h3C);
    wr(`SCC_ADDR_CLK_CFG, 8'hFF);
    rd(`SCC_ADDR_CLK_CFG, d);
    chk(d, {2'b00, 2'h1, `SCC_CLOCK_SOURCE_SELECT_EXT});
    @(posedge i_sys_clk) i_clock_source_select <= 4'h5;
    rd(`SCC_ADDR_CLK_CFG, d);
    chk(d, 8'h15);
    chk(o_ext_clk_mode, 1'b0);
    @(posedge i_sys_clk) i_clock_source_select <= `SCC_CLOCK_SOURCE_SELECT_EXT;
    rd(4'hF, d);
    chk(d, 8'h00);
    $display("Test registers done");
    @(posedge i_sys_clk) i_resetn <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    #1;
    chk(o_trim_value, 8'h80);
    chk(o_ext_clk_mode, 1'b1);
    rd(`SCC_ADDR_CORE_CTRL, d);
    chk(d, `SCC_CORE_CTRL_RST);
    $display("Test reset done");
    close_out;
  end
endmodule // sleep_and_clock_control_tb
